// File: rtl/pg_mask_rail_pkg.sv
// constants, field layouts and carrier types for the sleep-pin mask and rail control registers
`default_nettype none
package pg_mask_rail_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] sleep_pin_pg_mask_off          = 8'hac;
    localparam logic [7:0] termination_discharge_ctrl_off = 8'had;
    localparam logic [7:0] ldo_switch_ctrl_off            = 8'hae;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int out1_sleep3_mask_pos = 7;
    localparam int out1_sleep6_mask_pos = 6;
    localparam int out4_sleep3_mask_pos = 5;
    localparam int out4_sleep6_mask_pos = 4;
    localparam int out2_sleep3_mask_pos = 3;
    localparam int out2_sleep6_mask_pos = 2;
    localparam int out3_sleep3_mask_pos = 1;
    localparam int out3_sleep6_mask_pos = 0;
    localparam int termination_discharge_sel_pos = 4;
    localparam int ldo_discharge_sel_hi   = 7;
    localparam int ldo_discharge_sel_lo   = 6;
    localparam int emergency_off_config_pos = 5;
    localparam int ldo_voltage_code_hi    = 4;
    localparam int ldo_voltage_code_lo    = 1;
    localparam int ldo_switch_enable_pos  = 0;

    // ------------------------------------------------------------------
    // default factory values (the factory image port overrides them)
    // ------------------------------------------------------------------
    localparam logic [7:0] sleep_pin_pg_mask_dflt          = 8'hff;
    localparam logic [7:0] termination_discharge_ctrl_dflt = 8'h5f;
    localparam logic [7:0] ldo_switch_ctrl_dflt            = 8'h48;

    // ------------------------------------------------------------------
    // emergency shutdown off-time choices
    // ------------------------------------------------------------------
    localparam int clk_hz        = 20_000_000;
    localparam int off_time_1_ms   = 1;
    localparam int off_time_5_ms   = 5;
    localparam int off_time_10_ms  = 10;
    localparam int off_time_100_ms = 100;
    localparam int cycles_per_ms   = clk_hz / 1000;
    localparam int off_cycles_1    = off_time_1_ms * cycles_per_ms;
    localparam int off_cycles_5    = off_time_5_ms * cycles_per_ms;
    localparam int off_cycles_10   = off_time_10_ms * cycles_per_ms;
    localparam int off_cycles_100  = off_time_100_ms * cycles_per_ms;
    localparam int off_cnt_width   = 22;

    // variant routing of the ldo/switch group
    typedef enum logic [1:0] {
        target_unused,
        target_ldo,
        target_switch_two
    } rail_target_type;

    // factory one-time-programmed image
    typedef struct packed {
        logic [7:0]      sleep_pin_pg_mask;
        logic [7:0]      termination_discharge_ctrl;
        logic [7:0]      ldo_switch_ctrl;
        logic [1:0]      off_time_sel;
        rail_target_type target;
    } factory_image_type;

    // register bus carrier
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // power-good sources per output, plus the two sleep pins shared by all outputs
    typedef struct packed {
        logic [3:0] rails_good;
        logic       sleep_ctl_input_three;
        logic       sleep_ctl_input_six;
    } pg_inputs_type;

    // analog-facing rail controls
    typedef struct packed {
        logic       termination_discharge_on;
        logic [1:0] ldo_discharge_sel;
        logic [3:0] ldo_voltage_code;
        logic       ldo_on;
        logic       switch_two_on;
    } rail_ctrl_type;

    typedef enum logic [0:0] {
        st_run,
        st_emergency_off
    } off_state_type;

    typedef struct packed {
        logic [7:0]               sleep_pin_pg_mask_reg;
        logic [7:0]               termination_discharge_ctrl_reg;
        logic [7:0]               ldo_switch_ctrl_reg;
        logic [7:0]               rdata_reg;
        logic                     rvalid_reg;
        logic [3:0]               pg_out_reg;
        rail_ctrl_type            rail_reg;
        off_state_type            off_state_reg;
        logic [off_cnt_width-1:0] off_cnt_reg;
    } ctrl_state_type;

endpackage : pg_mask_rail_pkg
`default_nettype wire

// File: rtl/pg_mask_rail_ctrl_regs.sv
// sleep-pin power-good masking, discharge selection and ldo/switch control registers
`default_nettype none

module pg_mask_rail_ctrl_regs
    import pg_mask_rail_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // factory image
    input  wire factory_image_type factory_image,
    // register access from the serial host interface
    input  wire reg_req_type       reg_req,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    // power-good sources, one rail-good bundle per output
    input  wire pg_inputs_type     pg_inputs,
    input  wire logic              emergency_shutdown,
    // outputs
    output logic [3:0]             pg_out,
    output rail_ctrl_type          rail_ctrl
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // masked sources count as good
    function automatic logic pg_tree(input logic rail_good, input logic s3, input logic s6,
                                     input logic m3, input logic m6);
        pg_tree = rail_good & (s3 | m3) & (s6 | m6);
    endfunction : pg_tree

    function automatic logic [off_cnt_width-1:0] off_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    off_cycles = off_cnt_width'(off_cycles_1);
            2'h1:    off_cycles = off_cnt_width'(off_cycles_5);
            2'h2:    off_cycles = off_cnt_width'(off_cycles_10);
            default: off_cycles = off_cnt_width'(off_cycles_100);
        endcase
    endfunction : off_cycles

    ctrl_state_type state_reg;
    ctrl_state_type state_next;
    logic           cfg_follow_enable;
    logic           enable_bit;
    logic           rail_enabled;
    logic [7:0]     m;

    assign m                 = state_reg.sleep_pin_pg_mask_reg;
    assign cfg_follow_enable = state_reg.ldo_switch_ctrl_reg[emergency_off_config_pos];
    assign enable_bit        = state_reg.ldo_switch_ctrl_reg[ldo_switch_enable_pos];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next            = state_reg;
        state_next.rvalid_reg = 1'b0;

        // writes store all bits; reserved bits are kept as written
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                sleep_pin_pg_mask_off:          state_next.sleep_pin_pg_mask_reg = reg_req.wdata;
                termination_discharge_ctrl_off: begin
                    state_next.termination_discharge_ctrl_reg = reg_req.wdata;
                end
                ldo_switch_ctrl_off:            state_next.ldo_switch_ctrl_reg = reg_req.wdata;
                default:                        ;
            endcase
        end

        if (reg_req.rd_en) begin
            state_next.rvalid_reg = 1'b1;
            case (reg_req.addr)
                sleep_pin_pg_mask_off:          state_next.rdata_reg = m;
                termination_discharge_ctrl_off: begin
                    state_next.rdata_reg = state_reg.termination_discharge_ctrl_reg;
                end
                ldo_switch_ctrl_off:            state_next.rdata_reg = state_reg.ldo_switch_ctrl_reg;
                default:                        state_next.rdata_reg = 8'h00;
            endcase
        end

        // power-good trees per output
        state_next.pg_out_reg[0] = pg_tree(pg_inputs.rails_good[0], pg_inputs.sleep_ctl_input_three,
            pg_inputs.sleep_ctl_input_six, m[out1_sleep3_mask_pos], m[out1_sleep6_mask_pos]);
        state_next.pg_out_reg[1] = pg_tree(pg_inputs.rails_good[1], pg_inputs.sleep_ctl_input_three,
            pg_inputs.sleep_ctl_input_six, m[out2_sleep3_mask_pos], m[out2_sleep6_mask_pos]);
        state_next.pg_out_reg[2] = pg_tree(pg_inputs.rails_good[2], pg_inputs.sleep_ctl_input_three,
            pg_inputs.sleep_ctl_input_six, m[out3_sleep3_mask_pos], m[out3_sleep6_mask_pos]);
        state_next.pg_out_reg[3] = pg_tree(pg_inputs.rails_good[3], pg_inputs.sleep_ctl_input_three,
            pg_inputs.sleep_ctl_input_six, m[out4_sleep3_mask_pos], m[out4_sleep6_mask_pos]);

        // emergency shutdown with the config bit at 0 holds the rail off for the factory duration
        case (state_reg.off_state_reg)
            st_run: begin
                if (emergency_shutdown && !cfg_follow_enable) begin
                    state_next.off_state_reg = st_emergency_off;
                    state_next.off_cnt_reg   = off_cycles(factory_image.off_time_sel);
                end
            end
            st_emergency_off: begin
                if (state_reg.off_cnt_reg <= off_cnt_width'(1)) begin
                    state_next.off_state_reg = st_run;
                    state_next.off_cnt_reg   = '0;
                end else begin
                    state_next.off_cnt_reg = state_reg.off_cnt_reg - off_cnt_width'(1);
                end
            end
            default: state_next.off_state_reg = st_run;
        endcase

        state_next.rail_reg.termination_discharge_on =
            state_reg.termination_discharge_ctrl_reg[termination_discharge_sel_pos];
        state_next.rail_reg.ldo_discharge_sel =
            state_reg.ldo_switch_ctrl_reg[ldo_discharge_sel_hi:ldo_discharge_sel_lo];
        state_next.rail_reg.ldo_voltage_code =
            state_reg.ldo_switch_ctrl_reg[ldo_voltage_code_hi:ldo_voltage_code_lo];
        state_next.rail_reg.ldo_on        = 1'b0;
        state_next.rail_reg.switch_two_on = 1'b0;
        case (factory_image.target)
            target_ldo:        state_next.rail_reg.ldo_on = rail_enabled;
            target_switch_two: state_next.rail_reg.switch_two_on = rail_enabled;
            default:           ; // enable bit has no effect in this variant
        endcase

        // reset takes the factory image, not a fixed constant
        if (!rst_n) begin
            state_next                                = '0;
            state_next.sleep_pin_pg_mask_reg          = factory_image.sleep_pin_pg_mask;
            state_next.termination_discharge_ctrl_reg = factory_image.termination_discharge_ctrl;
            state_next.ldo_switch_ctrl_reg            = factory_image.ldo_switch_ctrl;
            state_next.off_state_reg                  = st_run;
        end
    end

    // gated by the shutdown timer only while config bit is 0
    // setting the config bit mid off-time hands the rail straight back to the enable bit
    assign rail_enabled = enable_bit &&
                          (cfg_follow_enable || (state_reg.off_state_reg == st_run));

    // ------------------------------------------------------------------
    // state register (reset is synchronous, so the image may be sampled)
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        state_reg <= state_next;
    end

    assign reg_rdata  = state_reg.rdata_reg;
    assign reg_rvalid = state_reg.rvalid_reg;
    assign pg_out     = state_reg.pg_out_reg;
    assign rail_ctrl  = state_reg.rail_reg;

endmodule : pg_mask_rail_ctrl_regs
`default_nettype wire

// File: bench/pg_mask_rail_ctrl_regs_checker.sv
// assertions on the sleep-pin mask and rail control register block
`default_nettype none
module pg_mask_rail_ctrl_regs_checker
    import pg_mask_rail_pkg::*;
(
    // watched ports
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire factory_image_type factory_image,
    input wire reg_req_type       reg_req,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire pg_inputs_type     pg_inputs,
    input wire logic              emergency_shutdown,
    input wire logic [3:0]        pg_out,
    input wire rail_ctrl_type     rail_ctrl
);
    logic [7:0] mask_reg, term_reg, ldo_reg, rd_calc;
    logic [3:0] pg_calc;
    logic       s3, s6;
    // shadow registers track writes so outputs can be judged without the body
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_reg <= factory_image.sleep_pin_pg_mask;
            term_reg <= factory_image.termination_discharge_ctrl;
            ldo_reg  <= factory_image.ldo_switch_ctrl;
        end else if (reg_req.wr_en) begin
            case (reg_req.addr)
                sleep_pin_pg_mask_off:          mask_reg <= reg_req.wdata;
                termination_discharge_ctrl_off: term_reg <= reg_req.wdata;
                ldo_switch_ctrl_off:            ldo_reg  <= reg_req.wdata;
                default:                        ;
            endcase
        end
    end
    always_comb begin
        case (reg_req.addr)
            sleep_pin_pg_mask_off:          rd_calc = mask_reg;
            termination_discharge_ctrl_off: rd_calc = term_reg;
            ldo_switch_ctrl_off:            rd_calc = ldo_reg;
            default:                        rd_calc = 8'h00;
        endcase
    end
    assign s3 = pg_inputs.sleep_ctl_input_three;
    assign s6 = pg_inputs.sleep_ctl_input_six;
    assign pg_calc = pg_inputs.rails_good & {(s3|mask_reg[5])&(s6|mask_reg[4]),
        (s3|mask_reg[1])&(s6|mask_reg[0]), (s3|mask_reg[3])&(s6|mask_reg[2]),
        (s3|mask_reg[7])&(s6|mask_reg[6])};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence emerg_hit;
        emergency_shutdown && !ldo_reg[5] && factory_image.target == target_ldo;
    endsequence
    read_answer_a: assert property (reg_req.rd_en |=> reg_rvalid && reg_rdata == $past(rd_calc))
        else $error("read answer wrong");
    stray_valid_a: assert property ($past(rst_n) && !$past(reg_req.rd_en) |-> !reg_rvalid)
        else $error("valid without read");
    pg_tree_a: assert property ($past(rst_n) |-> pg_out == $past(pg_calc))
        else $error("power good tree wrong");
    term_disch_a: assert property ($past(rst_n) |->
        rail_ctrl.termination_discharge_on == $past(term_reg[4]))
        else $error("termination discharge wrong");
    ldo_disch_a: assert property ($past(rst_n) |-> rail_ctrl.ldo_discharge_sel == $past(ldo_reg[7:6]))
        else $error("ldo discharge wrong");
    volt_code_a: assert property ($past(rst_n) |-> rail_ctrl.ldo_voltage_code == $past(ldo_reg[4:1]))
        else $error("voltage code wrong");
    emerg_off_a: assert property (emerg_hit |-> ##2 !rail_ctrl.ldo_on [*3])
        else $error("rail not off in shutdown");
    cfg_follow_a: assert property ($past(rst_n) && $past(ldo_reg[5]) && factory_image.target == target_ldo
        |-> rail_ctrl.ldo_on == $past(ldo_reg[0])) else $error("ldo not following enable");
    switch_route_a: assert property ($past(rst_n) && $past(ldo_reg[5])
        && factory_image.target == target_switch_two
        |-> !rail_ctrl.ldo_on && rail_ctrl.switch_two_on == $past(ldo_reg[0]))
        else $error("switch two routing wrong");
    unused_off_a: assert property (factory_image.target == target_unused
        |-> !rail_ctrl.ldo_on && !rail_ctrl.switch_two_on) else $error("unused rail driven");
endmodule : pg_mask_rail_ctrl_regs_checker
bind pg_mask_rail_ctrl_regs pg_mask_rail_ctrl_regs_checker pg_mask_rail_ctrl_regs_checker_i (
    .clk_sys, .rst_n, .factory_image, .reg_req, .reg_rdata, .reg_rvalid, .pg_inputs,
    .emergency_shutdown, .pg_out, .rail_ctrl);
`default_nettype wire

// File: bench/reg_host_model.sv
// host model issuing register requests at the falling edge
`default_nettype none
module reg_host_model
    import pg_mask_rail_pkg::*;
(
    // register bus
    input  wire logic       clk_sys,
    output var reg_req_type reg_req,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial reg_req = '{1'b0, 1'b0, 8'h00, 8'h00};
    // idle bus shows inverted leftovers so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b0, ~a, 8'hff};
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask : rd
endmodule : reg_host_model
`default_nettype wire

// File: bench/test_pg_mask_rail_ctrl_regs.sv
// self-checking bench for the sleep-pin mask and rail control registers
`default_nettype none
module test_pg_mask_rail_ctrl_regs
    import pg_mask_rail_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              emergency_shutdown = 1'b0;
    factory_image_type factory_image = '{8'h5a, 8'h5f, 8'h49, 2'd0, target_ldo};
    pg_inputs_type     pg_inputs = '{4'hf, 1'b1, 1'b1};
    reg_req_type       reg_req;
    logic [7:0]        reg_rdata, mask;
    logic              reg_rvalid;
    logic [3:0]        pg_out;
    rail_ctrl_type     rail_ctrl;
    int                failures = 0, checked = 0;
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    pg_mask_rail_ctrl_regs pg_mask_rail_ctrl_regs_i (.clk_sys, .rst_n, .factory_image, .reg_req,
        .reg_rdata, .reg_rvalid, .pg_inputs, .emergency_shutdown, .pg_out, .rail_ctrl);
    reg_host_model reg_host_model_i (.clk_sys, .reg_req, .reg_rdata, .reg_rvalid);
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checked++;
        if (act !== exp) begin
            failures++;
            $display("BAD t=%0t got %h want %h", $time, act, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        reg_host_model_i.rd(a, d);
        chk(d, e);
    endtask : rd_chk
    task automatic finish_test();
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // image may only change while reset is held
    task automatic restart(input rail_target_type tgt);
        @(negedge clk_sys);
        rst_n = 1'b0;
        factory_image.target = tgt;
        factory_image.ldo_switch_ctrl = 8'h21;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : restart
    function automatic logic [3:0] pg_want(logic [7:0] m, logic [3:0] g, logic a, logic b);
        return g & {(a|m[5])&(b|m[4]), (a|m[1])&(b|m[0]), (a|m[3])&(b|m[2]), (a|m[7])&(b|m[6])};
    endfunction : pg_want
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_chk(sleep_pin_pg_mask_off, 8'h5a);
        rd_chk(termination_discharge_ctrl_off, 8'h5f);
        rd_chk(ldo_switch_ctrl_off, 8'h49);
        rd_chk(8'haf, 8'h00);
        for (int m = 0; m < 10; m++) begin
            mask = (m < 8) ? 8'hff ^ (8'h01 << m) : ((m == 8) ? 8'h00 : 8'hff);
            reg_host_model_i.wr(sleep_pin_pg_mask_off, mask);
            for (int v = 0; v < 8; v++) begin
                pg_inputs = '{(v[2] ? 4'hd : 4'hf), v[0], v[1]};
                repeat (2) @(negedge clk_sys);
                chk({4'h0, pg_out}, {4'h0, pg_want(mask, pg_inputs.rails_good, v[0], v[1])});
            end
            rd_chk(sleep_pin_pg_mask_off, mask);
        end
        for (int k = 0; k < 4; k++) begin
            reg_host_model_i.wr(termination_discharge_ctrl_off, k[0] ? 8'h5f : 8'h4f);
            reg_host_model_i.wr(ldo_switch_ctrl_off, {k[1:0], 1'b1, 4'(5 * k + 3), 1'b1});
            repeat (2) @(negedge clk_sys);
            chk({7'h0, rail_ctrl.termination_discharge_on}, {7'h0, k[0]});
            chk({6'h0, rail_ctrl.ldo_discharge_sel}, {6'h0, k[1:0]});
            chk({4'h0, rail_ctrl.ldo_voltage_code}, {4'h0, 4'(5 * k + 3)});
        end
        reg_host_model_i.wr(ldo_switch_ctrl_off, 8'h20);
        repeat (2) @(negedge clk_sys);
        chk({7'h0, rail_ctrl.ldo_on}, 8'h00);
        for (int c = 0; c < 2; c++) begin
            reg_host_model_i.wr(ldo_switch_ctrl_off, c ? 8'h01 : 8'h21);
            emergency_shutdown = 1'b1;
            @(negedge clk_sys);
            emergency_shutdown = 1'b0;
            repeat (5) @(negedge clk_sys);
            chk({7'h0, rail_ctrl.ldo_on}, c ? 8'h00 : 8'h01);
        end
        repeat (off_cycles_1 - 20) @(negedge clk_sys);
        chk({7'h0, rail_ctrl.ldo_on}, 8'h00);
        repeat (30) @(negedge clk_sys);
        chk({7'h0, rail_ctrl.ldo_on}, 8'h01);
        reg_host_model_i.wr(ldo_switch_ctrl_off, 8'h01);
        emergency_shutdown = 1'b1;
        @(negedge clk_sys);
        emergency_shutdown = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk({7'h0, rail_ctrl.ldo_on}, 8'h00);
        // config set during the off-time: rail follows the enable bit at once
        reg_host_model_i.wr(ldo_switch_ctrl_off, 8'h21);
        repeat (2) @(negedge clk_sys);
        chk({7'h0, rail_ctrl.ldo_on}, 8'h01);
        rd_chk(ldo_switch_ctrl_off, 8'h21);
        restart(target_switch_two);
        chk({6'h0, rail_ctrl.ldo_on, rail_ctrl.switch_two_on}, 8'h01);
        restart(target_unused);
        chk({6'h0, rail_ctrl.ldo_on, rail_ctrl.switch_two_on}, 8'h00);
        finish_test();
    end
endmodule : test_pg_mask_rail_ctrl_regs
`default_nettype wire
